// ==== logic/tcc_capture_compare.sv ====
// Capture and compare front end of a 16-bit timer, APB slave with byte registers and a 14-bit control register.
// Assumes the counter, prescaler and pin logic are outside; inputs synchronous to clk.
//
// Overview of operation
// - Capture pin is the trigger by default; comparator output when select bit set.
// - Each trigger input has its own synchroniser; both share the filter and edge detector.
// - Enabled filter adds four clock cycles of delay before capture.
// - Capture trigger disabled only in modes using capture as ceiling; filter and edge detector keep running.
// - Filter output changes only after four equal consecutive samples.
// - Filter enabled by control bit, sampled on system clock, not prescaled.
// - Software driving the capture pin triggers capture like an external edge.
// - Every capture overwrites the capture register regardless of reads.
// - Enabled compare flag requests interrupt; cleared by acknowledge or writing one.
// - Channel A compare value can serve as counter ceiling.
// - PWM modes double-buffer compare values, loaded at ceiling or floor.
// - Compare access hits buffer in PWM, register otherwise; reads skip latch.
// - High byte to latch first; low write loads full 16 bits in one cycle.
// - Force strobe in non-PWM acts like a match without setting the flag.
// - A count write blocks every compare match at the next timer tick.
// - Output state survives waveform mode changes.
// - Output action bits act immediately, not buffered.
// - A capture copies the count and sets the flag in the same cycle.
// - Enabled capture flag requests interrupt; cleared by acknowledge or writing one.
`timescale 1ns/1ps
`default_nettype none
module tcc_capture_compare (
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [tcc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     capturePin,
    input  wire logic                     comparatorOutput,
    input  wire logic [15:0]              countValue,
    input  wire logic                     timerTick,
    input  wire logic                     countAtTop,
    input  wire logic                     countAtFloor,
    input  wire logic                     captureIrqAck,
    input  wire logic [1:0]               compareIrqAck,
    output logic                          captureIrq,
    output logic      [1:0]               compareIrq,
    output logic      [1:0]               compareOutputState,
    output logic      [15:0]              captureValueReg,
    output logic      [15:0]              compareValueA,
    output logic      [3:0]               waveformModeSel,
    output logic                          countWriteStb,
    output logic      [15:0]              countWriteData
);
    import tcc_pkg::*;

    logic [1:0]        rstPipe_q;
    logic              rstN;
    logic [CTRL_W-1:0] ctrl_q;
    logic [7:0]        temp_q;
    logic [15:0]       captVal_q;
    logic              captFlag_q;
    logic [1:0]        pinSync_q;
    logic [1:0]        acSync_q;
    logic [FILT_LEN-2:0] hist_q;
    logic              filt_q;
    logic              prev_q;
    logic              block_q;
    logic              captIrq_q;
    logic [1:0]        cmpIrq_q;
    logic              cntStb_q;
    logic [15:0]       cntData_q;
    logic [31:0]       rdMux;
    logic              rdOk;
    logic [15:0]       cmpVal [2];
    logic [15:0]       bufVal [2];
    logic [1:0]        cmpFlag;
    logic [1:0]        ocState;
    logic [1:0]        cmpHit;

    // Reset release through two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) rstPipe_q <= 2'h0;
        else         rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
    assign rstN = rstPipe_q[1];

    wire [3:0] wgm      = ctrl_q[CB_WGM +: 4];
    wire       pwmMode  = tccIsPwm(wgm);
    wire       captTop  = tccCaptTop(wgm);
    wire       updPoint = tccUpdFloor(wgm) ? countAtFloor : countAtTop;
    wire       setup    = psel & ~penable;
    wire       wrAcc    = psel & penable & pwrite & pready;
    wire       rdSetup  = setup & ~pwrite;
    wire [7:0] wb       = pwdata[7:0];
    wire       wrCtrl   = wrAcc && paddr == OFF_CTRL;
    wire       wrFlags  = wrAcc && paddr == OFF_FLAGS;
    wire       wrCaptL  = wrAcc && paddr == OFF_CAPT_L && captTop;
    wire       wrCntL   = wrAcc && paddr == OFF_CNT_L;
    wire [1:0] forceStb = (wrAcc && paddr == OFF_FORCE && !pwmMode) ? pwdata[1:0] : 2'h0;
    wire [1:0] cmpWrL   = {wrAcc && paddr == OFF_CMPB_L, wrAcc && paddr == OFF_CMPA_L};
    wire       wrHigh   = wrAcc && (paddr == OFF_CAPT_H || paddr == OFF_CMPA_H
                                 || paddr == OFF_CMPB_H || paddr == OFF_CNT_H);
    wire [15:0] wrWord  = {temp_q, wb};

    // Trigger source select after two-flop synchronisers
    wire       srcLvl   = ctrl_q[CB_ACSEL] ? acSync_q[1] : pinSync_q[1];
    wire       allHigh  = &{hist_q, srcLvl};
    wire       allLow   = ~|{hist_q, srcLvl};
    wire       level    = ctrl_q[CB_FILT] ? filt_q : srcLvl;
    wire       edgeHit  = ctrl_q[CB_EDGE] ? (level & ~prev_q) : (~level & prev_q);
    wire       captTrig = edgeHit & ~captTop;
    wire       captClr  = captureIrqAck | (wrFlags & pwdata[0]);

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pinSync_q <= 2'h0;
            acSync_q  <= 2'h0;
            hist_q    <= '0;
            filt_q    <= 1'b0;
            prev_q    <= 1'b0;
        end else begin
            pinSync_q <= {pinSync_q[0], capturePin};
            acSync_q  <= {acSync_q[0], comparatorOutput};
            hist_q    <= {hist_q[FILT_LEN-3:0], srcLvl};
            if (allHigh)     filt_q <= 1'b1;
            else if (allLow) filt_q <= 1'b0;
            prev_q    <= level;
        end
    end

    // Capture register and flag; set wins over clear
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            captVal_q  <= CMP_RST;
            captFlag_q <= 1'b0;
        end else begin
            if (captTrig)     captVal_q <= countValue;
            else if (wrCaptL) captVal_q <= wrWord;
            captFlag_q <= captTrig | (captFlag_q & ~captClr);
        end
    end

    // Compare channels
    for (genvar ch = 0; ch < 2; ch++) begin : gChan
        logic [15:0] cmp_q;
        logic [15:0] buf_q;
        logic        flag_q;
        logic        oc_q;
        wire  [1:0]  act  = ctrl_q[(ch == 0 ? CB_ACTA : CB_ACTB) +: 2];
        wire         hit  = timerTick && countValue == cmp_q && !block_q;
        wire         clr  = compareIrqAck[ch] | (wrFlags & pwdata[ch+1]);
        wire         fire = hit | forceStb[ch];
        wire         topAct = pwmMode && countAtTop && !hit;
        always_ff @(posedge clk or negedge rstN) begin
            if (!rstN) begin
                cmp_q  <= CMP_RST;
                buf_q  <= CMP_RST;
                flag_q <= 1'b0;
                oc_q   <= 1'b0;
            end else begin
                if (cmpWrL[ch]) buf_q <= wrWord;
                if (cmpWrL[ch] && !pwmMode) cmp_q <= wrWord;
                else if (pwmMode && updPoint) cmp_q <= buf_q;
                flag_q <= hit | (flag_q & ~clr);
                if (fire && act == ACT_TOGGLE)   oc_q <= ~oc_q;
                else if (fire && act == ACT_CLEAR) oc_q <= pwmMode;
                else if (fire && act == ACT_SET)   oc_q <= ~pwmMode;
                else if (topAct && act == ACT_CLEAR) oc_q <= 1'b0;
                else if (topAct && act == ACT_SET)   oc_q <= 1'b1;
            end
        end
        assign cmpVal[ch]  = cmp_q;
        assign bufVal[ch]  = buf_q;
        assign cmpFlag[ch] = flag_q;
        assign ocState[ch] = oc_q;
        assign cmpHit[ch]  = hit;
    end

    // Read decode; compare reads bypass the high-byte latch
    always_comb begin
        rdOk  = 1'b1;
        rdMux = 32'h0000_0000;
        case (paddr)
            OFF_CTRL:   rdMux[CTRL_W-1:0] = ctrl_q;
            OFF_FORCE:  rdMux = 32'h0000_0000;
            OFF_FLAGS:  rdMux[2:0] = {cmpFlag, captFlag_q};
            OFF_CAPT_L: rdMux[7:0] = captVal_q[7:0];
            OFF_CAPT_H: rdMux[7:0] = temp_q;
            OFF_CMPA_L: rdMux[7:0] = pwmMode ? bufVal[0][7:0] : cmpVal[0][7:0];
            OFF_CMPA_H: rdMux[7:0] = pwmMode ? bufVal[0][15:8] : cmpVal[0][15:8];
            OFF_CMPB_L: rdMux[7:0] = pwmMode ? bufVal[1][7:0] : cmpVal[1][7:0];
            OFF_CMPB_H: rdMux[7:0] = pwmMode ? bufVal[1][15:8] : cmpVal[1][15:8];
            OFF_CNT_L:  rdMux[7:0] = countValue[7:0];
            OFF_CNT_H:  rdMux[7:0] = temp_q;
            OFF_OUT:    rdMux[1:0] = ocState;
            default:    rdOk = 1'b0;
        endcase
    end

    // APB answer one cycle after setup, zero wait states
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~rdOk;
            if (rdSetup) prdata <= rdOk ? rdMux : 32'h0000_0000;
        end
    end

    // Control, shared high-byte latch, count write and match blocking
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ctrl_q    <= CTRL_RST;
            temp_q    <= 8'h00;
            block_q   <= 1'b0;
            cntStb_q  <= 1'b0;
            cntData_q <= 16'h0000;
            captIrq_q <= 1'b0;
            cmpIrq_q  <= 2'h0;
        end else begin
            if (wrCtrl) ctrl_q <= pwdata[CTRL_W-1:0];
            if (wrHigh) temp_q <= wb;
            else if (rdSetup && paddr == OFF_CAPT_L) temp_q <= captVal_q[15:8];
            else if (rdSetup && paddr == OFF_CNT_L)  temp_q <= countValue[15:8];
            block_q   <= wrCntL | (block_q & ~(timerTick & ~cntStb_q));
            cntStb_q  <= wrCntL;
            if (wrCntL) cntData_q <= wrWord;
            captIrq_q <= captFlag_q & ctrl_q[CB_IEC];
            cmpIrq_q  <= cmpFlag & ctrl_q[CB_IEA +: 2];
        end
    end

    assign captureIrq         = captIrq_q;
    assign compareIrq         = cmpIrq_q;
    assign compareOutputState = ocState;
    assign captureValueReg    = captVal_q;
    assign compareValueA      = cmpVal[0];
    assign waveformModeSel    = ctrl_q[CB_WGM +: 4];
    assign countWriteStb      = cntStb_q;
    assign countWriteData     = cntData_q;

    // Count written and not yet past a tick: the first tick on the new count
    logic wrSeen_q;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) wrSeen_q <= 1'b0;
        else       wrSeen_q <= cntStb_q | (wrSeen_q & ~timerTick);
    end

    chk_capture_copy: assert property (@(posedge clk) disable iff (!rstN)
        captTrig |=> captVal_q == $past(countValue) && captFlag_q)
        else $error("capture did not copy count and set flag");
    chk_capture_setwins: assert property (@(posedge clk) disable iff (!rstN)
        captTrig && captClr |=> captFlag_q)
        else $error("capture flag lost to clear");
    chk_ceiling_nocap: assert property (@(posedge clk) disable iff (!rstN)
        captTop && !wrCaptL |=> $stable(captVal_q))
        else $error("capture in ceiling mode");
    chk_filter_agree: assert property (@(posedge clk) disable iff (!rstN)
        ctrl_q[CB_FILT] && $changed(filt_q) |->
        $past(srcLvl, 1) == filt_q && $past(srcLvl, 2) == filt_q &&
        $past(srcLvl, 3) == filt_q && $past(srcLvl, 4) == filt_q)
        else $error("filter changed without four equal samples");
    chk_cmp_flag: assert property (@(posedge clk) disable iff (!rstN)
        timerTick && countValue == cmpVal[0] && !block_q |=> cmpFlag[0])
        else $error("compare match did not set flag");
    chk_block_match: assert property (@(posedge clk) disable iff (!rstN)
        wrSeen_q && timerTick && cmpFlag == 2'h0 |=> cmpFlag == 2'h0)
        else $error("match not blocked after count write");
    chk_force_noflag: assert property (@(posedge clk) disable iff (!rstN)
        forceStb[0] && !cmpHit[0] && !cmpFlag[0] && ctrl_q[CB_ACTA +: 2] == ACT_SET
        |=> !cmpFlag[0] && ocState[0])
        else $error("force misbehaved");
    chk_pwm_buffer: assert property (@(posedge clk) disable iff (!rstN)
        pwmMode && cmpWrL[0] && !updPoint |=> cmpVal[0] == $past(cmpVal[0]))
        else $error("buffered compare changed early");
    chk_write_pair: assert property (@(posedge clk) disable iff (!rstN)
        cmpWrL[0] && !pwmMode |=> cmpVal[0] == {$past(temp_q), $past(wb)})
        else $error("compare low write did not load full word");
    chk_apb_answer: assert property (@(posedge clk) disable iff (!rstN)
        setup |=> pready)
        else $error("no answer after setup");
    chk_apb_error: assert property (@(posedge clk) disable iff (!rstN)
        setup && !rdOk |=> pready && pslverr)
        else $error("unmapped access without error");
    chk_capture_ack: assert property (@(posedge clk) disable iff (!rstN)
        captureIrqAck && !captTrig |=> !captFlag_q)
        else $error("capture flag not cleared by acknowledge");
    chk_cmp_ack: assert property (@(posedge clk) disable iff (!rstN)
        compareIrqAck[0] && !cmpHit[0] |=> !cmpFlag[0])
        else $error("compare flag not cleared by acknowledge");
    chk_cmp_flagb: assert property (@(posedge clk) disable iff (!rstN)
        timerTick && countValue == cmpVal[1] && !block_q |=> cmpFlag[1])
        else $error("compare match on channel B did not set flag");
    chk_count_strobe: assert property (@(posedge clk) disable iff (!rstN)
        wrCntL |=> countWriteStb && countWriteData == {$past(temp_q), $past(wb)})
        else $error("count write did not carry full word");
endmodule : tcc_capture_compare
`default_nettype wire

// ==== logic/tcc_pkg.sv ====
// Package for the timer capture/compare front end: register map, fields, resets.
// Assumes byte-wide registers, except the 14-bit control register, carried in the low bits of 32-bit APB words.
package tcc_pkg;
    localparam int          ADDR_W     = 8;
    localparam logic [7:0]  OFF_CTRL   = 8'h00;
    localparam logic [7:0]  OFF_FORCE  = 8'h04;
    localparam logic [7:0]  OFF_FLAGS  = 8'h08;
    localparam logic [7:0]  OFF_CAPT_L = 8'h0C;
    localparam logic [7:0]  OFF_CAPT_H = 8'h10;
    localparam logic [7:0]  OFF_CMPA_L = 8'h14;
    localparam logic [7:0]  OFF_CMPA_H = 8'h18;
    localparam logic [7:0]  OFF_CMPB_L = 8'h1C;
    localparam logic [7:0]  OFF_CMPB_H = 8'h20;
    localparam logic [7:0]  OFF_CNT_L  = 8'h24;
    localparam logic [7:0]  OFF_CNT_H  = 8'h28;
    localparam logic [7:0]  OFF_OUT    = 8'h2C;
    // Control register fields
    localparam int          CTRL_W     = 14;
    localparam int          CB_FILT    = 0;
    localparam int          CB_EDGE    = 1;
    localparam int          CB_ACSEL   = 2;
    localparam int          CB_WGM     = 3;
    localparam int          CB_ACTA    = 7;
    localparam int          CB_ACTB    = 9;
    localparam int          CB_IEC     = 11;
    localparam int          CB_IEA     = 12;
    localparam logic [13:0] CTRL_RST   = 14'h0000;
    localparam logic [15:0] CMP_RST    = 16'h0000;
    localparam int          FILT_LEN   = 4;
    localparam logic [1:0]  ACT_TOGGLE = 2'h1;
    localparam logic [1:0]  ACT_CLEAR  = 2'h2;
    localparam logic [1:0]  ACT_SET    = 2'h3;

    function automatic logic tccIsPwm(input logic [3:0] m);
        return !(m == 4'h0 || m == 4'h4 || m == 4'hC || m == 4'hD);
    endfunction : tccIsPwm

    function automatic logic tccCaptTop(input logic [3:0] m);
        return (m == 4'h8 || m == 4'hA || m == 4'hC || m == 4'hE);
    endfunction : tccCaptTop

    function automatic logic tccUpdFloor(input logic [3:0] m);
        return (m == 4'h8 || m == 4'h9);
    endfunction : tccUpdFloor
endpackage : tcc_pkg

// ==== bench/tcc_timer_model.sv ====
// Stand-in external counter: count value, timer tick and ceiling/floor pulses.
// Assumes count writes arrive from the block as countWriteStb/countWriteData.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_model #(
    parameter logic [15:0] TOP = 16'h00FF
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        run,
    input  wire logic        countWriteStb,
    input  wire logic [15:0] countWriteData,
    output logic      [15:0] countValue,
    output logic             timerTick,
    output logic             countAtTop,
    output logic             countAtFloor
);
    logic [1:0] div_q;
    // One tick every fourth clock while running, none while stopped
    assign timerTick    = run && (div_q == 2'h3);
    assign countAtTop   = timerTick && (countValue == TOP);
    assign countAtFloor = timerTick && (countValue == 16'h0000);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q      <= 2'h0;
            countValue <= 16'h0000;
        end else begin
            div_q <= run ? div_q + 2'h1 : div_q;
            // Software writes win over counting
            if (countWriteStb)
                countValue <= countWriteData;
            else if (timerTick)
                countValue <= (countValue == TOP) ? 16'h0000 : countValue + 16'h0001;
        end
    end
endmodule : tcc_timer_model
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for tcc_capture_compare over APB.
// Assumes tcc_timer_model stands in for the external counter.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tcc_pkg::*;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic r;} tcc_row_t;
    logic        clk = 1'h0, arst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic        capturePin = 1'h0, comparatorOutput = 1'h0, run = 1'h0;
    logic        captureIrqAck = 1'h0;
    logic [1:0]  compareIrqAck = 2'h0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, timerTick, countAtTop, countAtFloor, countWriteStb;
    logic        captureIrq;
    logic [1:0]  compareIrq, compareOutputState;
    logic [3:0]  waveformModeSel;
    logic [15:0] countValue, captureValueReg, compareValueA, countWriteData;
    int          failures = 0, n_tests = 0, lu, lf, n;
    tcc_row_t    rows [12] = '{
        '{1'h0, OFF_CTRL, 32'h0, 32'h0, 1'h0}, '{1'h0, OFF_FLAGS, 32'h0, 32'h0, 1'h0},
        '{1'h0, OFF_OUT, 32'h0, 32'h0, 1'h0}, '{1'h1, OFF_CAPT_L, 32'h55, 32'h0, 1'h0},
        '{1'h0, OFF_CAPT_L, 32'h0, 32'h0, 1'h0}, '{1'h1, OFF_CMPA_H, 32'h12, 32'h0, 1'h0},
        '{1'h1, OFF_CMPA_L, 32'h34, 32'h0, 1'h0}, '{1'h0, OFF_CMPA_L, 32'h0, 32'h34, 1'h0},
        '{1'h0, OFF_CMPA_H, 32'h0, 32'h12, 1'h0}, '{1'h0, OFF_FORCE, 32'h0, 32'h0, 1'h0},
        '{1'h1, 8'h30, 32'h1, 32'h0, 1'h1}, '{1'h0, 8'h30, 32'h0, 32'h0, 1'h1}};

    tcc_capture_compare u_tcc_capture_compare (.clk(clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capturePin(capturePin),
        .comparatorOutput(comparatorOutput), .countValue(countValue), .timerTick(timerTick),
        .countAtTop(countAtTop), .countAtFloor(countAtFloor), .captureIrqAck(captureIrqAck),
        .compareIrqAck(compareIrqAck), .captureIrq(captureIrq), .compareIrq(compareIrq),
        .compareOutputState(compareOutputState), .captureValueReg(captureValueReg),
        .compareValueA(compareValueA), .waveformModeSel(waveformModeSel),
        .countWriteStb(countWriteStb), .countWriteData(countWriteData));
    tcc_timer_model u_tcc_timer_model (.clk(clk), .arst_n(arst_n), .run(run),
        .countWriteStb(countWriteStb), .countWriteData(countWriteData),
        .countValue(countValue), .timerTick(timerTick), .countAtTop(countAtTop),
        .countAtFloor(countAtFloor));

    always #2 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("comparisons=%0d mismatches=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim

    // Setup cycle, then hold until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel   <= 1'h1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'h1 && k < 16);
        if (k >= 16) begin
            failures++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        check(rd, e);
    endtask : rdc

    // High byte first, low byte commits the whole value
    task automatic wr16(input logic [7:0] h, input logic [7:0] l, input logic [15:0] v);
        wr(h, {24'h0, v[15:8]});
        wr(l, {24'h0, v[7:0]});
    endtask : wr16

    task automatic tick_run(input logic [15:0] v, input int c);
        wr16(OFF_CNT_H, OFF_CNT_L, v);
        run <= 1'h1;
        repeat (c) @(posedge clk);
        run <= 1'h0;
    endtask : tick_run

    // Loads the count, flips one trigger input, counts cycles until captured (30 = none)
    task automatic pin_lat(input logic src, input logic [15:0] v, output int k);
        wr16(OFF_CNT_H, OFF_CNT_L, v);
        if (src)
            comparatorOutput <= ~comparatorOutput;
        else
            capturePin <= ~capturePin;
        k = 0;
        while (captureValueReg !== v && k < 30) begin
            @(posedge clk);
            k++;
        end
    endtask : pin_lat

    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'h1;
        repeat (3) @(posedge clk);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w)
                check(rd, rows[i].e);
            check(32'(err), 32'(rows[i].r));
        end
        check(32'(compareValueA), 32'h00001234);
        $display("register table done");
        wr(OFF_CTRL, 32'h00000802);
        pin_lat(1'h0, 16'h0ABC, lu);
        check(32'(captureValueReg), 32'h00000ABC);
        rdc(OFF_FLAGS, 32'h00000001);
        check(32'(captureIrq), 32'h00000001);
        captureIrqAck <= 1'h1;
        @(posedge clk);
        captureIrqAck <= 1'h0;
        rdc(OFF_FLAGS, 32'h00000000);
        check(32'(captureIrq), 32'h00000000);
        wr(OFF_CTRL, 32'h00000000);
        // Acknowledge lands in the capture cycle: the set must win
        wr16(OFF_CNT_H, OFF_CNT_L, 16'h0B0B);
        capturePin <= 1'h0;
        repeat (2) @(posedge clk);
        captureIrqAck <= 1'h1;
        @(posedge clk);
        captureIrqAck <= 1'h0;
        rdc(OFF_FLAGS, 32'h00000001);
        check(32'(captureValueReg), 32'h00000B0B);
        capturePin <= 1'h1;
        pin_lat(1'h0, 16'h0BBB, n);
        check(32'(captureValueReg), 32'h00000BBB);
        pin_lat(1'h0, 16'h0CCC, n);
        check(32'(n), 32'h0000001E);
        wr(OFF_CTRL, 32'h00000004);
        wr(OFF_FLAGS, 32'h00000001);
        pin_lat(1'h0, 16'h0C0C, n);
        check(32'(n), 32'h0000001E);
        wr(OFF_CTRL, 32'h00000006);
        pin_lat(1'h1, 16'h0DDD, lu);
        check(32'(captureValueReg), 32'h00000DDD);
        wr(OFF_CTRL, 32'h00000007);
        wr16(OFF_CNT_H, OFF_CNT_L, 16'h0EEE);
        comparatorOutput <= 1'h0;
        repeat (2) @(posedge clk);
        comparatorOutput <= 1'h1;
        repeat (20) @(posedge clk);
        check(32'(captureValueReg), 32'h00000DDD);
        pin_lat(1'h1, 16'h0F0F, n);
        pin_lat(1'h1, 16'h0A5A, lf);
        check(32'(lf), 32'(lu + 4));
        wr(OFF_CTRL, 32'h00000062);
        pin_lat(1'h0, 16'h0777, n);
        check(32'(n), 32'h0000001E);
        wr16(OFF_CAPT_H, OFF_CAPT_L, 16'h1357);
        check(32'(captureValueReg), 32'h00001357);
        $display("capture tests done");
        wr(OFF_FLAGS, 32'h00000007);
        wr(OFF_CTRL, 32'h00001200);
        wr16(OFF_CMPA_H, OFF_CMPA_L, 16'h0010);
        wr16(OFF_CMPB_H, OFF_CMPB_L, 16'h0010);
        tick_run(16'h000E, 40);
        rdc(OFF_FLAGS, 32'h00000006);
        check(32'(compareOutputState), 32'h00000002);
        check(32'(compareIrq), 32'h00000001);
        compareIrqAck <= 2'h1;
        @(posedge clk);
        compareIrqAck <= 2'h0;
        rdc(OFF_FLAGS, 32'h00000004);
        check(32'(compareIrq), 32'h00000000);
        wr(OFF_FLAGS, 32'h00000006);
        tick_run(16'h0010, 4);
        rdc(OFF_FLAGS, 32'h00000000);
        check(32'(compareOutputState), 32'h00000002);
        wr(OFF_CTRL, 32'h00000180);
        wr(OFF_FORCE, 32'h00000001);
        repeat (2) @(posedge clk);
        check(32'(compareOutputState), 32'h00000003);
        rdc(OFF_FLAGS, 32'h00000000);
        wr(OFF_CTRL, 32'h00000128);
        check(32'(waveformModeSel), 32'h00000005);
        check(32'(compareOutputState), 32'h00000003);
        wr(OFF_FORCE, 32'h00000001);
        repeat (2) @(posedge clk);
        check(32'(compareOutputState), 32'h00000003);
        wr16(OFF_CMPA_H, OFF_CMPA_L, 16'h0055);
        check(32'(compareValueA), 32'h00000010);
        rdc(OFF_CMPA_L, 32'h00000055);
        tick_run(16'h00FE, 12);
        check(32'(compareValueA), 32'h00000055);
        // Second reset in mid-run clears state at once
        arst_n <= 1'h0;
        repeat (2) @(posedge clk);
        check(32'(captureValueReg), 32'h00000000);
        check(32'(compareOutputState), 32'h00000000);
        arst_n <= 1'h1;
        repeat (3) @(posedge clk);
        rdc(OFF_CTRL, 32'h00000000);
        $display("compare and reset tests done");
        end_sim();
    end
endmodule : tb
`default_nettype wire
